/* logic/iip_top.v */
// Behaviour
// - 32 lines as four bytes, low line D0
// - Port read returns present line states
// - Written 1 forces line to read 0
// - Reset clears every port output bit
// - Mask bits 0-3 block port writes
// - Mask bits 4-7 do nothing in standard
// - Mask clear after reset
// - Port 7 bits 7:6 select/report bank
// - Enhanced mode offers three banks
// - Bank 00 inputs, 01 events, 10 debounce
// - Reset gives standard mode, bank 0
// - Bank 1 ports 0-3 read event flops
// - Writing 0 clears an event flop
// - Writing 1 re-arms sensing on a line
// - Summary bits 0-3 show port pending
// - Summary bit 7 set on any event
// - Flag routable to interrupt request line
// - Enable bit 0 gates irq; bit 1 resets
// - Polarity 1 falling, 0 rising edge
// - Upper data byte never driven
`default_nettype none
`include "iip_regs.vh"

module iip_top (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Field inputs, asynchronous
  input wire [31:0] field_input_lines,
  // Register access port
  input wire reg_sel,
  input wire reg_wr,
  input wire [5:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg reg_ack,
  output reg [7:0] reg_rdata,
  output wire reg_lo_oe_n,
  output wire reg_hi_oe_n,
  // Carrier interrupt
  output wire carrier_interrupt_request_zero
);

  // ----------------------------------------------------------------
  // Unlock sequence states
  // ----------------------------------------------------------------
  localparam U_WAIT0 = 3'b000;
  localparam U_WAIT1 = 3'b001;
  localparam U_WAIT2 = 3'b010;
  localparam U_WAIT3 = 3'b011;
  localparam U_OPEN = 3'b100;
  localparam U_SHUT = 3'b101;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Pick one eight-line port out of the 32 lines
  function [7:0] port_byte;
    input [31:0] vec;
    input [2:0] idx;
    begin
      port_byte = vec[idx[1:0]*`IIP_PORT_W +: `IIP_PORT_W];
    end
  endfunction

  // Expected key byte for an unlock step
  function [7:0] key_for;
    input [2:0] st;
    begin
      case (st)
        U_WAIT0: key_for = `IIP_KEY0;
        U_WAIT1: key_for = `IIP_KEY1;
        U_WAIT2: key_for = `IIP_KEY2;
        U_WAIT3: key_for = `IIP_KEY3;
        default: key_for = `IIP_BYTE_RST;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  wire [31:0] line_sync;     // Synchronised field lines
  reg soft_rst;              // Software reset pulse
  wire rst_all;              // Power-up or software reset
  reg [31:0] port_force;     // Written port bits, force read 0
  reg [31:0] line_prev;      // Previous live level for edges
  reg [31:0] evt;            // Event-sense flip-flops
  reg [31:0] arm;            // Event sensing enabled per line
  reg [7:0] polarity;        // Edge polarity per nibble
  reg [7:0] vector;          // Interrupt vector storage
  reg [3:0] mask;            // Port write mask
  reg [1:0] bank;            // Selected bank
  reg [2:0] unl_state;       // Unlock progress
  reg [2:0] next_unl_state;  // Unlock next state
  reg irq_en;                // Interrupt line enable
  reg ack_rd;                // Read answer is on the bus
  reg [31:0] pol_line;       // Polarity fanned out per line
  reg [31:0] next_force;     // Next forced bits
  reg [31:0] evt_clr;        // Event clear strobes
  reg [31:0] next_arm;       // Next arm bits
  reg [7:0] next_rdata;      // Read mux
  reg [3:0] port_pend;       // Per-port pending summary
  integer i;
  wire [31:0] line_live;
  wire [31:0] edge_hit;
  wire irq_flag;
  wire wr_req;
  wire rd_req;
  wire is_port;
  wire [2:0] idx;
  wire mapped;
  wire enh_mode;
  wire [1:0] bank_eff;

  // ----------------------------------------------------------------
  // Field line synchroniser
  // ----------------------------------------------------------------
  iip_sync u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .d(field_input_lines),
    .q(line_sync)
  );

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  assign rst_all = sys_rst | soft_rst;
  assign wr_req = reg_sel & reg_wr;
  assign rd_req = reg_sel & ~reg_wr;
  assign is_port = (reg_addr[5:3] == `IIP_FILL3);
  assign idx = reg_addr[2:0];
  // Unused addresses get no answer
  assign mapped = is_port | (reg_addr == `IIP_IRQ_EN) | (reg_addr == `IIP_VECTOR);
  assign enh_mode = (unl_state == U_OPEN);
  // Standard mode behaves as bank 0
  assign bank_eff = enh_mode ? bank : `IIP_BANK_IN;

  // Forced bits read as 0 and hide line changes
  assign line_live = line_sync & ~port_force;

  // ----------------------------------------------------------------
  // Edge detect and summaries
  // ----------------------------------------------------------------
  always @* begin
    for (i = 0; i < `IIP_NLINES; i = i + 1) begin
      pol_line[i] = polarity[i >> `IIP_NIBBLE_SH];
    end
    for (i = 0; i < `IIP_NPORTS; i = i + 1) begin
      port_pend[i] = |evt[i*`IIP_PORT_W +: `IIP_PORT_W];
    end
  end

  // Falling edge when polarity is 1, rising when 0
  assign edge_hit = (~line_live & line_prev & pol_line) |
                    (line_live & ~line_prev & ~pol_line);
  assign irq_flag = |port_pend;
  // Flag reaches the carrier line only when enabled
  assign carrier_interrupt_request_zero = irq_flag & irq_en;

  // Upper byte is never driven, low byte only while answering
  assign reg_hi_oe_n = 1'b1;
  assign reg_lo_oe_n = ~ack_rd;

  // ----------------------------------------------------------------
  // Unlock sequence next state
  // ----------------------------------------------------------------
  always @* begin
    next_unl_state = unl_state;
    case (unl_state)
      U_WAIT0, U_WAIT1, U_WAIT2, U_WAIT3: begin
        if (reg_sel) begin
          if (reg_addr != `IIP_PORT7) begin
            // Any other address aborts the sequence
            next_unl_state = U_SHUT;
          end else if (reg_wr) begin
            if (reg_wdata != key_for(unl_state)) begin
              next_unl_state = U_SHUT;
            end else if (unl_state == U_WAIT3) begin
              next_unl_state = U_OPEN;
            end else begin
              next_unl_state = unl_state + 3'b001;
            end
          end
        end
      end
      U_OPEN: next_unl_state = U_OPEN;
      U_SHUT: next_unl_state = U_SHUT;
      default: next_unl_state = U_SHUT;
    endcase
  end

  // ----------------------------------------------------------------
  // Write side effects on port bits and event controls
  // ----------------------------------------------------------------
  always @* begin
    next_force = port_force;
    evt_clr = `IIP_LINES_RST;
    next_arm = arm;
    if (wr_req && is_port && (idx < `IIP_NPORTS)) begin
      if (bank_eff == `IIP_BANK_IN) begin
        // Masked ports ignore writes
        if (!mask[idx[1:0]]) begin
          next_force[idx[1:0]*`IIP_PORT_W +: `IIP_PORT_W] = reg_wdata;
        end
      end else if (bank_eff == `IIP_BANK_EVT) begin
        // Zero clears the flop, one re-arms the line
        evt_clr[idx[1:0]*`IIP_PORT_W +: `IIP_PORT_W] = ~reg_wdata;
        next_arm[idx[1:0]*`IIP_PORT_W +: `IIP_PORT_W] = reg_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (rst_all) begin
      port_force <= `IIP_LINES_RST;
      mask <= `IIP_MASK_RST;
      bank <= `IIP_BANK_IN;
      unl_state <= U_WAIT0;
      polarity <= `IIP_BYTE_RST;
      vector <= `IIP_BYTE_RST;
      irq_en <= 1'b0;
    end else begin
      port_force <= next_force;
      unl_state <= next_unl_state;
      if (wr_req && (reg_addr == `IIP_PORT7)) begin
        // Only bank 0 and standard mode hold the mask
        if (bank_eff == `IIP_BANK_IN) begin
          mask <= reg_wdata[`IIP_MASK_HI:0];
        end
        // Code 11 is refused and the bank kept
        if (enh_mode && (reg_wdata[`IIP_BANK_HI:`IIP_BANK_LO] != `IIP_BANK_BAD)) begin
          bank <= reg_wdata[`IIP_BANK_HI:`IIP_BANK_LO];
        end
      end
      if (wr_req && (reg_addr == `IIP_PORT6) && (bank_eff == `IIP_BANK_EVT)) begin
        polarity <= reg_wdata;
      end
      if (wr_req && (reg_addr == `IIP_IRQ_EN)) begin
        irq_en <= reg_wdata[`IIP_IE_IRQ];
      end
      if (wr_req && (reg_addr == `IIP_VECTOR)) begin
        vector <= reg_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Event sensing
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (rst_all) begin
      evt <= `IIP_LINES_RST;
      arm <= `IIP_LINES_RST;
      line_prev <= `IIP_LINES_RST;
    end else begin
      line_prev <= line_live;
      arm <= next_arm;
      // A new edge wins over a clear in the same cycle
      evt <= (evt & ~evt_clr) | (edge_hit & arm);
    end
  end

  // ----------------------------------------------------------------
  // Software reset pulse
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (sys_rst || soft_rst) begin
      soft_rst <= 1'b0;
    end else begin
      soft_rst <= wr_req & (reg_addr == `IIP_IRQ_EN) & reg_wdata[`IIP_IE_SWRST];
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always @* begin
    next_rdata = `IIP_BYTE_RST;
    if (reg_addr == `IIP_IRQ_EN) begin
      next_rdata = {`IIP_FILL6, 1'b0, irq_en};
    end else if (reg_addr == `IIP_VECTOR) begin
      next_rdata = vector;
    end else if (is_port) begin
      case (bank_eff)
        `IIP_BANK_IN: begin
          if (idx < `IIP_NPORTS) begin
            next_rdata = port_byte(line_live, idx);
          end else if (reg_addr == `IIP_PORT7) begin
            next_rdata = {bank, `IIP_FILL2, mask};
          end
        end
        `IIP_BANK_EVT: begin
          if (idx < `IIP_NPORTS) begin
            next_rdata = port_byte(evt, idx);
          end else if (reg_addr == `IIP_PORT6) begin
            next_rdata = {irq_flag, `IIP_FILL3, port_pend};
          end else if (reg_addr == `IIP_PORT7) begin
            next_rdata = {bank, `IIP_FILL6};
          end
        end
        `IIP_BANK_DEB: begin
          if (reg_addr == `IIP_PORT7) begin
            next_rdata = {bank, `IIP_FILL6};
          end
        end
        default: next_rdata = `IIP_BYTE_RST;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Bus answer, one cycle after the strobe
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      reg_ack <= 1'b0;
      ack_rd <= 1'b0;
      reg_rdata <= `IIP_BYTE_RST;
    end else begin
      reg_ack <= reg_sel & mapped;
      ack_rd <= rd_req & mapped;
      if (rd_req && mapped) begin
        reg_rdata <= next_rdata;
      end
    end
  end

endmodule

`default_nettype wire

/* logic/iip_regs.vh */
`ifndef IIP_REGS_VH
`define IIP_REGS_VH

// ----------------------------------------------------------------
// Register word addresses (odd byte lane, byte address = 2*addr+1)
// ----------------------------------------------------------------
`define IIP_PORT0      6'h00
`define IIP_PORT6      6'h06
`define IIP_PORT7      6'h07
`define IIP_IRQ_EN     6'h0f
`define IIP_VECTOR     6'h17

// ----------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------
`define IIP_NPORTS     4
`define IIP_NLINES     32
`define IIP_PORT_W     8
`define IIP_NIBBLE_SH  2

// ----------------------------------------------------------------
// Unlock key bytes, in order
// ----------------------------------------------------------------
`define IIP_KEY0       8'h07
`define IIP_KEY1       8'h0d
`define IIP_KEY2       8'h06
`define IIP_KEY3       8'h12

// ----------------------------------------------------------------
// Bank codes and field positions
// ----------------------------------------------------------------
`define IIP_BANK_IN    2'b00
`define IIP_BANK_EVT   2'b01
`define IIP_BANK_DEB   2'b10
`define IIP_BANK_BAD   2'b11
`define IIP_BANK_HI    7
`define IIP_BANK_LO    6
`define IIP_MASK_HI    3
`define IIP_IE_IRQ     0
`define IIP_IE_SWRST   1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define IIP_MASK_RST   4'h0
`define IIP_BYTE_RST   8'h00
`define IIP_LINES_RST  32'h0000_0000
`define IIP_FILL6      6'h00
`define IIP_FILL4      4'h0
`define IIP_FILL3      3'h0
`define IIP_FILL2      2'h0

`endif

/* logic/iip_sync.v */
`default_nettype none
`include "iip_regs.vh"

module iip_sync (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Asynchronous field lines in
  input wire [31:0] d,
  // Lines on the clock domain out
  output reg [31:0] q
);

  // First stage, read only by the second stage
  reg [31:0] meta;

  // ----------------------------------------------------------------
  // Two-flop synchroniser
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      meta <= `IIP_LINES_RST;
      q <= `IIP_LINES_RST;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule

`default_nettype wire

/* test/iip_chk.sv */
`default_nettype none
`include "iip_regs.vh"

module iip_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Field lines
  input wire logic [31:0] field_input_lines,
  // Register port
  input wire logic reg_sel,
  input wire logic reg_wr,
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_ack,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_lo_oe_n,
  input wire logic reg_hi_oe_n,
  // Interrupt
  input wire logic carrier_interrupt_request_zero
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Common clocking and the strobe decode
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Strobe to an address that answers
  wire logic hit = reg_sel && (reg_addr <= `IIP_PORT7 || reg_addr == `IIP_IRQ_EN ||
    reg_addr == `IIP_VECTOR);

  // ----------------------------------------------------------------
  // Register port answers
  // ----------------------------------------------------------------
  chk_ack_mapped: assert property (hit |=> reg_ack)
    else $error("mapped access not answered");
  chk_unmapped_silent: assert property (reg_sel && !hit |=> !reg_ack)
    else $error("unmapped access answered");
  chk_ack_cause: assert property (reg_ack |-> $past(reg_sel))
    else $error("answer without a strobe");
  chk_read_drive: assert property (hit && !reg_wr |=> !reg_lo_oe_n)
    else $error("read answer not driven");
  chk_oe_pairs_ack: assert property (!reg_lo_oe_n |-> reg_ack && !$past(reg_wr))
    else $error("low byte driven outside a read answer");
  chk_hi_undriven: assert property (reg_hi_oe_n)
    else $error("upper byte driven");
  chk_rdata_hold: assert property (reg_lo_oe_n |-> $stable(reg_rdata))
    else $error("read data moved without a read");
  chk_reset_clears: assert property (disable iff (1'b0) sys_rst |=>
    !reg_ack && reg_rdata == 8'h00 && reg_lo_oe_n && !carrier_interrupt_request_zero)
    else $error("outputs not cleared by reset");
endmodule

bind iip_top iip_chk u_iip_chk (
  .clk(clk), .sys_rst(sys_rst), .field_input_lines(field_input_lines),
  .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_ack(reg_ack), .reg_rdata(reg_rdata), .reg_lo_oe_n(reg_lo_oe_n),
  .reg_hi_oe_n(reg_hi_oe_n),
  .carrier_interrupt_request_zero(carrier_interrupt_request_zero)
);

`default_nettype wire

/* test/iip_host.sv */
`default_nettype none

module iip_host (
  // Clock and answer
  input wire logic clk,
  input wire logic reg_ack,
  input wire logic [7:0] reg_rdata,
  // Request
  output logic reg_sel,
  output logic reg_wr,
  output logic [5:0] reg_addr,
  output logic [7:0] reg_wdata
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Idle bus
  // ----------------------------------------------------------------
  initial begin
    reg_sel = 1'b0;
    reg_wr = 1'b0;
    reg_addr = 6'h3f;
    reg_wdata = 8'h5a;
  end

  // ----------------------------------------------------------------
  // One access: strobe one cycle, answer taken a cycle later
  // ----------------------------------------------------------------
  // Only whole bytes travel; bank code 11 is offered only by t_lock_fail, while the port is locked
  task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] d,
    output logic ack, output logic [7:0] q);
    @(negedge clk);
    reg_sel = 1'b1;
    reg_wr = w;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    ack = reg_ack;
    q = reg_rdata;
    reg_sel = 1'b0;
    // Released data shows the inverse, not the last value
    reg_wdata = ~d;
  endtask
endmodule

`default_nettype wire

/* test/iip_top_tb.sv */
`default_nettype none

module iip_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Clock, reset, wiring
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [31:0] lines = 32'h0;
  logic sel, wr, ack, lo_oe_n, hi_oe_n, irq;
  logic [5:0] addr;
  logic [7:0] wdata, rdata;
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;
  always #5 clk = ~clk;

  iip_top u_iip_top (.clk(clk), .sys_rst(sys_rst), .field_input_lines(lines),
    .reg_sel(sel), .reg_wr(wr), .reg_addr(addr), .reg_wdata(wdata), .reg_ack(ack),
    .reg_rdata(rdata), .reg_lo_oe_n(lo_oe_n), .reg_hi_oe_n(hi_oe_n),
    .carrier_interrupt_request_zero(irq));
  iip_host u_iip_host (.clk(clk), .reg_ack(ack), .reg_rdata(rdata), .reg_sel(sel),
    .reg_wr(wr), .reg_addr(addr), .reg_wdata(wdata));

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task automatic tally_and_finish;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Single-bit results: answer strobe and interrupt line
  task automatic cmp1(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    logic k;
    logic [7:0] q;
    u_iip_host.acc(1'b0, a, 8'h00, k, q);
    cmp1(k, 1'b1);
    cmp8(q, exp);
  endtask
  task automatic put(input logic [5:0] a, input logic [7:0] d);
    logic k;
    logic [7:0] q;
    u_iip_host.acc(1'b1, a, d, k, q);
    cmp1(k, 1'b1);
  endtask
  // New line levels, then time for sync and edge detect
  task automatic set_lines(input logic [31:0] v);
    @(negedge clk);
    lines = v;
    repeat (4) @(negedge clk);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_lock_fail;
    logic k;
    logic [7:0] q;
    rd(6'h07, 8'h00);
    put(6'h07, 8'h07);
    put(6'h07, 8'h0d);
    put(6'h07, 8'h05);
    put(6'h07, 8'h12);
    put(6'h07, 8'hf3);
    rd(6'h07, 8'h03);
    u_iip_host.acc(1'b0, 6'h08, 8'h00, k, q);
    cmp1(k, 1'b0);
    $display("test lock_fail done");
  endtask
  task automatic t_force_mask;
    put(6'h07, 8'h00);
    set_lines(32'h8421_c3a5);
    for (int p = 0; p < 4; p++) rd(p[5:0], lines[8*p+:8]);
    put(6'h00, 8'h0f);
    set_lines(lines ^ 32'h1);
    rd(6'h00, lines[7:0] & 8'hf0);
    put(6'h07, 8'h01);
    put(6'h00, 8'h00);
    rd(6'h00, lines[7:0] & 8'hf0);
    rd(6'h07, 8'h01);
    $display("test force_mask done");
  endtask
  task automatic t_unlock_bank;
    @(negedge clk);
    sys_rst = 1'b1;
    repeat (6) @(negedge clk);
    sys_rst = 1'b0;
    put(6'h07, 8'h07);
    put(6'h07, 8'h0d);
    put(6'h07, 8'h06);
    put(6'h07, 8'h12);
    rd(6'h07, 8'h02);
    rd(6'h00, lines[7:0]);
    put(6'h07, 8'h40);
    rd(6'h07, 8'h40);
    $display("test unlock_bank done");
  endtask
  task automatic t_events;
    set_lines(32'h0);
    put(6'h06, 8'h00);
    put(6'h00, 8'hff);
    put(6'h01, 8'hff);
    set_lines(32'h0000_0201);
    rd(6'h00, 8'h01);
    rd(6'h01, 8'h02);
    rd(6'h02, 8'h00);
    rd(6'h06, 8'h83);
    put(6'h00, 8'hfe);
    rd(6'h00, 8'h00);
    rd(6'h06, 8'h82);
    set_lines(32'h0000_0200);
    set_lines(32'h0000_0201);
    rd(6'h00, 8'h00);
    put(6'h06, 8'h01);
    put(6'h00, 8'hff);
    set_lines(32'h0000_0200);
    rd(6'h00, 8'h01);
    $display("test events done");
  endtask
  task automatic t_irq_swrst;
    put(6'h0f, 8'h01);
    cmp1(irq, 1'b1);
    rd(6'h0f, 8'h01);
    put(6'h07, 8'h80);
    rd(6'h07, 8'h80);
    rd(6'h00, 8'h00);
    put(6'h07, 8'h0f);
    put(6'h07, 8'h0f);
    rd(6'h07, 8'h0f);
    put(6'h0f, 8'h00);
    cmp1(irq, 1'b0);
    rd(6'h0f, 8'h00);
    put(6'h17, 8'ha5);
    rd(6'h17, 8'ha5);
    put(6'h0f, 8'h02);
    repeat (3) @(negedge clk);
    rd(6'h07, 8'h00);
    rd(6'h17, 8'h00);
    $display("test irq_swrst done");
  endtask

  // ----------------------------------------------------------------
  // Hang guard and main sequence
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (6) @(negedge clk);
    sys_rst = 1'b0;
    t_lock_fail();
    t_force_mask();
    t_unlock_bank();
    t_events();
    t_irq_swrst();
    tally_and_finish;
  end
endmodule

`default_nettype wire
